// ==== src/wos_steer.sv ====
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module wos_steer
  import wos_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        mod_data_i,
  input  wire logic        shutdown_i,
  output logic [3:0]       wave_pins_o
);
  wos_state_s s_r;
  wos_state_s s_nxt;

  logic bus_req;
  logic wr_steer_en;
  logic wr_steer_ovr;
  logic wr_config;
  logic steer_mode;
  logic sync_mode;
  logic rise;

  // mode 00x is steering; the upper codes leave every pin at its static level
  function automatic logic is_steer_mode(
    input logic [2:0] mode
  );
    return (mode[2:1] == 2'b00); // R1
  endfunction

  function automatic logic is_sync_mode(
    input logic [2:0] mode
  );
    return (mode == WOS_MODE_SYNC); // R9
  endfunction

  // a write lands only on the edge where waitrequest is sampled low
  function automatic logic lane_write(
    input logic       write,
    input logic       busy,
    input logic [3:0] addr,
    input logic [3:0] ofs,
    input logic [3:0] be,
    input int         lane
  );
    logic hit;
    hit = write && !busy && (addr == ofs);
    return hit && be[lane];
  endfunction

  function automatic logic [3:0] nib(
    input logic [31:0] w,
    input int          lsb
  );
    return w[lsb +: 4];
  endfunction

  function automatic logic rise_seen(
    input logic now_lvl,
    input logic old_lvl
  );
    return now_lvl && !old_lvl;
  endfunction

  function automatic logic [31:0] read_steer(
    input wos_state_s s
  );
    logic [31:0] v;
    v = 32'h0;
    // software reads back what it last wrote, even while still pending
    v[WOS_STEER_EN_LSB +: 4] = s.pend ? s.steer_pend : s.steer_act;
    v[WOS_OVR_LSB +: 4]      = s.ovr;
    return v;
  endfunction

  function automatic logic [31:0] read_config(
    input wos_state_s s
  );
    logic [31:0] v;
    v = 32'h0;
    v[WOS_POL_LSB +: 4]  = s.pol;
    v[WOS_MODE_LSB +: 3] = s.mode;
    v[WOS_SDLVL_BIT]     = s.sd_lvl;
    return v;
  endfunction

  function automatic logic [31:0] read_status(
    input wos_state_s s
  );
    logic [31:0] v;
    v = 32'h0;
    v[WOS_ACT_LSB +: 4]  = s.steer_act;
    v[WOS_PEND_LSB +: 4] = s.steer_pend;
    v[WOS_PENDF_BIT]     = s.pend;
    v[WOS_SHDN_BIT]      = s.sd_s2;
    return v;
  endfunction

  function automatic logic [31:0] read_mux(
    input logic [3:0] a,
    input wos_state_s s
  );
    logic [31:0] v;
    case (a)
      WOS_OFS_STEER: begin
        v = read_steer(s);
      end
      WOS_OFS_CONFIG: begin
        v = read_config(s);
      end
      WOS_OFS_STATUS: begin
        v = read_status(s);
      end
      default: begin
        v = 32'h0;
      end
    endcase
    return v;
  endfunction

  // one pin: static level, shutdown level or the modulated input
  function automatic logic pin_level(
    input logic steering,
    input logic act,
    input logic sd,
    input logic sd_lvl,
    input logic data,
    input logic pol,
    input logic ovr
  );
    logic lvl;
    if (!steering || !act) begin
      lvl = ovr; // R3 R6 R11
    end else if (sd) begin
      lvl = sd_lvl; // R7
    end else begin
      lvl = data ^ pol; // R4 R6
    end
    return lvl;
  endfunction

  // uses the next steer set, so a handover and the data edge meet in one cycle
  function automatic logic [3:0] pins_next(
    input wos_state_s cur,
    input logic [3:0] act,
    input logic       steering
  );
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < WOS_NPIN; i++) begin
      p[i] = pin_level(steering, act[i], cur.sd_s2, cur.sd_lvl,
                       cur.data_s2, cur.pol[i], cur.ovr[i]); // R2 R5
    end
    return p;
  endfunction

  // two flops per pin input; the third data flop only feeds the edge detector
  function automatic wos_state_s step_sync(
    input wos_state_s cur,
    input wos_state_s nxt,
    input logic       data_pin,
    input logic       sd_pin
  );
    wos_state_s r;
    r         = nxt;
    r.data_s1 = data_pin;
    r.data_s2 = cur.data_s1;
    r.data_d  = cur.data_s2;
    r.sd_s1   = sd_pin;
    r.sd_s2   = cur.sd_s1;
    return r;
  endfunction

  // handover only on a synchronised rising edge, so no pin is cut mid-pulse;
  // leaving sync mode flushes whatever is still waiting
  function automatic wos_state_s step_shadow(
    input wos_state_s cur,
    input wos_state_s nxt,
    input logic       rise,
    input logic       sync_mode
  );
    wos_state_s r;
    r = nxt;
    if (cur.pend && rise) begin
      r.steer_act = cur.steer_pend; // R9 R10 R12
      r.pend      = 1'b0;
    end
    if (cur.pend && !sync_mode) begin
      r.steer_act = cur.steer_pend;
      r.pend      = 1'b0;
    end
    return r;
  endfunction

  function automatic wos_state_s step_steer_write(
    input wos_state_s  nxt,
    input logic [31:0] wdata,
    input logic        sync_mode
  );
    wos_state_s r;
    logic [3:0] en;
    r  = nxt;
    en = nib(wdata, WOS_STEER_EN_LSB);
    if (sync_mode) begin
      r.steer_pend = en; // R12
      r.pend       = 1'b1;
    end else begin
      r.steer_act  = en; // R8
      r.steer_pend = en;
      r.pend       = 1'b0;
    end
    return r;
  endfunction

  function automatic wos_state_s step_ovr_write(
    input wos_state_s  nxt,
    input logic [31:0] wdata
  );
    wos_state_s r;
    r     = nxt;
    r.ovr = nib(wdata, WOS_OVR_LSB); // R11
    return r;
  endfunction

  function automatic wos_state_s step_config_write(
    input wos_state_s  nxt,
    input logic [31:0] wdata
  );
    wos_state_s r;
    r        = nxt;
    r.pol    = nib(wdata, WOS_POL_LSB);
    r.mode   = wdata[WOS_MODE_LSB +: 3];
    r.sd_lvl = wdata[WOS_SDLVL_BIT];
    return r;
  endfunction

  // waitrequest idles high, drops for one cycle once a request is seen and
  // rises again on the edge that takes it; read data is latched alongside
  function automatic wos_state_s step_bus(
    input wos_state_s cur,
    input wos_state_s nxt,
    input logic       req,
    input logic [3:0] addr
  );
    wos_state_s r;
    r         = nxt;
    r.wait_rq = !(req && cur.wait_rq);
    r.rdata   = read_mux(addr, cur);
    return r;
  endfunction

  always_comb begin
    s_nxt        = s_r;
    bus_req      = avs_read_i || avs_write_i;

    wr_steer_en  = lane_write(avs_write_i, s_r.wait_rq, avs_address_i, WOS_OFS_STEER, avs_byteenable_i, 0);
    wr_steer_ovr = lane_write(avs_write_i, s_r.wait_rq, avs_address_i, WOS_OFS_STEER, avs_byteenable_i, 1);
    wr_config    = lane_write(avs_write_i, s_r.wait_rq, avs_address_i, WOS_OFS_CONFIG, avs_byteenable_i, 0);

    steer_mode   = is_steer_mode(s_r.mode);
    sync_mode    = is_sync_mode(s_r.mode);
    rise         = rise_seen(s_r.data_s2, s_r.data_d);

    s_nxt = step_sync(s_r, s_nxt, mod_data_i, shutdown_i);
    s_nxt = step_shadow(s_r, s_nxt, rise, sync_mode);

    // a write wins over a handover in the same cycle
    if (wr_steer_en) begin
      s_nxt = step_steer_write(s_nxt, avs_writedata_i, sync_mode);
    end
    if (wr_steer_ovr) begin
      s_nxt = step_ovr_write(s_nxt, avs_writedata_i);
    end
    if (wr_config) begin
      s_nxt = step_config_write(s_nxt, avs_writedata_i);
    end

    s_nxt      = step_bus(s_r, s_nxt, bus_req, avs_address_i);
    s_nxt.pins = pins_next(s_r, s_nxt.steer_act, steer_mode);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= WOS_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o    = s_r.rdata;
  assign avs_waitrequest_o = s_r.wait_rq;
  assign wave_pins_o       = s_r.pins;

endmodule

// ==== src/wos_pkg.sv ====
// Operation
// [R1] mode 00x selects steering; wave output pins may carry the modulated signal
// [R2] same modulated signal on several pins at once, others held fixed
// [R3] steer enable clear: pin holds its static override level
// [R4] steer enable set: pin driven from the input data signal
// [R5] four pins steered independently, any subset of them
// [R6] polarity applies only to steered pins; static pins ignore it
// [R7] auto-shutdown changes only steered pins
// [R8] mode 000: new steer enables apply at end of the write
// [R9] mode 001: new steer enables wait for next input rising edge
// [R10] synchronous steering never makes a partial pulse
// [R11] static level comes from per-pin override bit in steer control register
// [R12] pending steer enables sit in a shadow, transferred on input rising edge
package wos_pkg;
  localparam int          WOS_NPIN         = 4;
  localparam logic [3:0]  WOS_OFS_STEER    = 4'h0;
  localparam logic [3:0]  WOS_OFS_CONFIG   = 4'h4;
  localparam logic [3:0]  WOS_OFS_STATUS   = 4'h8;
  // steer control: [3:0] steer enables, [11:8] override levels
  localparam int          WOS_STEER_EN_LSB = 0;
  localparam int          WOS_OVR_LSB      = 8;
  // config: [3:0] polarity, [6:4] mode, [7] shutdown level
  localparam int          WOS_POL_LSB      = 0;
  localparam int          WOS_MODE_LSB     = 4;
  localparam int          WOS_SDLVL_BIT    = 7;
  // status: [3:0] active steer, [7:4] pending shadow, [8] pending flag, [9] shutdown
  localparam int          WOS_ACT_LSB      = 0;
  localparam int          WOS_PEND_LSB     = 4;
  localparam int          WOS_PENDF_BIT    = 8;
  localparam int          WOS_SHDN_BIT     = 9;
  localparam logic [2:0]  WOS_MODE_ASYNC   = 3'h0;
  localparam logic [2:0]  WOS_MODE_SYNC    = 3'h1;
  localparam logic [2:0]  WOS_MODE_RST     = 3'h0;
  localparam logic [3:0]  WOS_NIB_RST      = 4'h0;
  // waitrequest idles high so a read is never answered before its data is latched
  localparam logic        WOS_WAIT_RST     = 1'b1;

  typedef struct packed {
    logic [3:0] steer_act;
    logic [3:0] steer_pend;
    logic       pend;
    logic [3:0] ovr;
    logic [3:0] pol;
    logic [2:0] mode;
    logic       sd_lvl;
    logic       data_s1;
    logic       data_s2;
    logic       data_d;
    logic       sd_s1;
    logic       sd_s2;
    logic       wait_rq;
    logic [31:0] rdata;
    logic [3:0] pins;
  } wos_state_s;

  localparam wos_state_s  WOS_STATE_RST    = '{wait_rq: WOS_WAIT_RST, default: '0};
endpackage

// ==== testbench/wos_props_properties.sv ====
`timescale 1ns/1ns
module wos_props (
  input logic        clk_i,
  input logic        rstn_i,
  input logic [3:0]  avs_address_i,
  input logic        avs_read_i,
  input logic        avs_write_i,
  input logic [31:0] avs_writedata_i,
  input logic [31:0] avs_readdata_o,
  input logic        avs_waitrequest_o,
  input logic        mod_data_i,
  input logic        shutdown_i,
  input logic [3:0]  wave_pins_o
);
  logic [3:0] st_r, ov_r, pl_r;
  logic [2:0] md_r;
  logic [1:0] up_r;
  logic       sl_r;
  wire        q = up_r == 2'h3 && md_r == 3'h0;
  // shadow assumes full byte lanes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {st_r, ov_r, pl_r, md_r, up_r, sl_r} <= '0;
    end else begin
      up_r <= up_r + 2'(up_r != 2'h3);
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) begin
        {ov_r, st_r} <= {avs_writedata_i[11:8], avs_writedata_i[3:0]};
      end
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4) begin
        {sl_r, md_r, pl_r} <= avs_writedata_i[7:0];
      end
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_wr_onewait: assert property (avs_write_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("write late");
  a_rd_first: assert property ($rose(avs_read_i) |-> avs_waitrequest_o) else $error("read early");
  a_rd_onewait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("read late");
  a_rd_unmapped: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[1:0] != 2'h0
    |-> avs_readdata_o == 32'h0) else $error("unmapped");
  a_static_pin: assert property (q |=> ((wave_pins_o ^ $past(ov_r)) & ~st_r) == 4'h0) else $error("static");
  a_steer_data: assert property (q && !$past(shutdown_i, 2)
    |=> ((wave_pins_o ^ $past(pl_r) ^ {4{$past(mod_data_i, 3)}}) & st_r) == 4'h0) else $error("steer");
  a_sd_steered: assert property (q && $past(shutdown_i, 2)
    |=> ((wave_pins_o ^ {4{$past(sl_r)}}) & st_r) == 4'h0) else $error("shutdown");
  a_mode_other: assert property (up_r == 2'h3 && md_r[2:1] != 2'h0 |=> wave_pins_o == $past(ov_r)) else $error("mode");
endmodule
bind wos_steer wos_props u_wos_props (.*);

// ==== testbench/wos_load.sv ====
`timescale 1ns/1ns
module wos_load (
  input logic        clk_i,
  input logic [3:0]  pins_i,
  output logic [7:0] rises_o = 8'h0
);
  logic last_r = 1'b0;
  // counts pulses on pin 0; a sliver would add one
  always @(posedge clk_i) begin
    last_r  <= pins_i[0];
    rises_o <= rises_o + 8'(pins_i[0] & ~last_r);
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic        clk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic        mod_data_i = 1'b0, shutdown_i = 1'b0, avs_waitrequest_o;
  logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hF, wave_pins_o;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [7:0]  rises;
  int          err_total = 0, num_checks = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  wos_steer u_wos_steer (.*);
  wos_load u_wos_load (.clk_i, .pins_i(wave_pins_o), .rises_o(rises));
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %0t seen %h want %h", $time, s, e);
    end
  endtask
  // reads pass the expected value in d
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_i); while (avs_waitrequest_o);
    if (!w) chk(avs_readdata_o, d);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pin(input logic [3:0] e);
    repeat (4) @(posedge clk_i);
    chk(32'(wave_pins_o), 32'(e));
  endtask
  task automatic close_out;
    $display("mismatches %0d checks %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 900) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    bus(1, 4'h4, 32'h6);
    bus(1, 4'h0, 32'hA05);
    mod_data_i <= 1'b1;
    pin(4'hB);
    mod_data_i <= 1'b0;
    pin(4'hE);
    shutdown_i <= 1'b1;
    pin(4'hA);
    shutdown_i <= 1'b0;
    bus(1, 4'h0, 32'hA0F);
    pin(4'h6);
    bus(1, 4'h4, 32'h20);
    pin(4'hA);
    bus(0, 4'h9, 32'h0);
    bus(1, 4'h4, 32'h16);
    bus(1, 4'h0, 32'hA00);
    bus(0, 4'h8, 32'h10F);
    pin(4'h6);
    mod_data_i <= 1'b1;
    pin(4'hA);
    chk(32'(rises), 32'h1);
    close_out();
  end
endmodule
